// ===== external_memory_bus_interface.sv
// external memory and peripheral bus sequencer with hold handshake
// assumes requests and register accesses are synchronous to clk_sys;
// the pad ring resolves each pin from its value and output enable
`timescale 1ns/1ns
`include "ext_bus_map.svh"
module external_memory_bus_interface (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // internal request side
  input wire logic req_valid,
  output logic req_ready,
  input wire ext_bus_pkg::bus_req_t req_in,
  output logic rsp_valid,
  output logic [31:0] rsp_rdata,
  // address and data pins
  output logic [23:0] addr_out,
  output logic addr_oe,
  input wire logic [31:0] data_in,
  output logic [31:0] data_out,
  output logic data_oe,
  // strobes and direction
  output logic read_not_write,
  output logic read_not_write_oe,
  output logic peripheral_io_strobe_n,
  output logic peripheral_io_strobe_oe,
  output logic [3:0] memory_strobe_set_a_lanes,
  output logic [3:0] memory_strobe_set_b_lanes,
  output logic memory_strobe_oe,
  // handshake and control pins
  input wire logic ready_in,
  input wire logic hold_request_n,
  output logic bus_hold_grant_n,
  output logic bus_hold_grant_oe,
  input wire logic program_width_select,
  input wire logic shutdown_high_z
);

  ext_bus_pkg::ctrl_state_t cur;
  ext_bus_pkg::ctrl_state_t next_cur;

  logic hold_ignore;
  logic hold_take;
  logic in_access;
  logic in_held;
  logic accept;
  logic beat_done;
  logic last;
  logic bus_drive;
  logic [1:0] accept_width;
  logic [4:0] shift;
  logic set_a_active;
  logic set_b_active;

  // last beat index for a given memory width
  function automatic logic [1:0] last_beat(input logic [1:0] w);
    case (w)
      `WIDTH_16: last_beat = 2'h1;
      `WIDTH_8: last_beat = 2'h3;
      default: last_beat = 2'h0;
    endcase
  endfunction

  // bit offset of the current beat inside the 32-bit word
  function automatic logic [4:0] beat_shift(input logic [1:0] w, input logic [1:0] b);
    case (w)
      `WIDTH_16: beat_shift = {b[0], 4'h0};
      `WIDTH_8: beat_shift = {b, 3'h0};
      default: beat_shift = 5'h00;
    endcase
  endfunction

  // reserved code 3 behaves as 32-bit so a bad write cannot hang the bus
  function automatic logic [1:0] clean_width(input logic [31:0] ctrl);
    logic [1:0] w;
    w = ctrl[`CTRL_WIDTH_LO +: 2];
    clean_width = (w == `WIDTH_8 || w == `WIDTH_16) ? w : `WIDTH_32;
  endfunction

  always_comb begin
    hold_ignore = cur.ctrl_a[`CTRL_HOLD_IGNORE];
    hold_take = ~hold_request_n & ~hold_ignore;
    in_access = (cur.state == ext_bus_pkg::ST_ACCESS);
    in_held = (cur.state == ext_bus_pkg::ST_HELD);
    // a pending hold is taken before a new request, never mid-transaction
    req_ready = (cur.state == ext_bus_pkg::ST_IDLE) & ~hold_take & ~reset; // [R11]
    accept = req_valid & req_ready;
    beat_done = in_access & ready_in; // [R8]
    last = (cur.beat == last_beat(cur.width));
    shift = beat_shift(cur.width, cur.beat);
    if (req_in.io) begin
      accept_width = `WIDTH_32;
    end else if (req_in.fetch) begin
      // program width follows the fetch-width bit, not the data width
      accept_width = cur.ctrl_a[`CTRL_PRG16] ? `WIDTH_16 : `WIDTH_32; // [R14] [R15]
    end else begin
      accept_width = req_in.set_b ? clean_width(cur.ctrl_b) : clean_width(cur.ctrl_a);
    end
  end

  always_comb begin
    next_cur = cur;
    next_cur.rsp_valid = 1'b0;
    next_cur.reg_rdata = 32'h00000000;
    if (reg_read) begin
      case (reg_addr)
        `OFF_CTRL_A: next_cur.reg_rdata = cur.ctrl_a;
        `OFF_CTRL_B: next_cur.reg_rdata = cur.ctrl_b;
        `OFF_STATUS: begin
          next_cur.reg_rdata[`STAT_ACCESS] = in_access;
          next_cur.reg_rdata[`STAT_HELD] = in_held;
          next_cur.reg_rdata[`STAT_HOLD_PENDING] = hold_take;
        end
        default: next_cur.reg_rdata = 32'h00000000;
      endcase
    end
    if (reg_write) begin
      case (reg_addr)
        `OFF_CTRL_A: next_cur.ctrl_a = reg_wdata & `CTRL_MASK;
        `OFF_CTRL_B: next_cur.ctrl_b = reg_wdata & `CTRL_MASK;
        default: next_cur.ctrl_a = cur.ctrl_a;
      endcase
    end
    case (cur.state)
      ext_bus_pkg::ST_IDLE: begin
        if (hold_take) begin
          next_cur.state = ext_bus_pkg::ST_HELD; // [R12]
        end else if (accept) begin
          next_cur.state = ext_bus_pkg::ST_ACCESS;
          next_cur.req = req_in;
          next_cur.width = accept_width;
          next_cur.beat = 2'h0;
          next_cur.rdata = 32'h00000000;
        end
      end
      ext_bus_pkg::ST_ACCESS: begin
        if (beat_done) begin
          if (!cur.req.write) begin
            case (cur.width)
              `WIDTH_16: next_cur.rdata[shift +: 16] = data_in[15:0]; // [R2] [R15]
              `WIDTH_8: next_cur.rdata[shift +: 8] = data_in[7:0];
              default: next_cur.rdata = data_in; // [R2]
            endcase
          end
          if (last) begin
            next_cur.rsp_valid = 1'b1;
            // hold waits for the whole word, all beats included
            next_cur.state = hold_take ? ext_bus_pkg::ST_HELD : ext_bus_pkg::ST_IDLE; // [R9]
          end else begin
            next_cur.beat = cur.beat + 2'h1;
          end
        end
      end
      ext_bus_pkg::ST_HELD: begin
        if (!hold_take) begin
          next_cur.state = ext_bus_pkg::ST_IDLE; // [R11]
        end
      end
      default: next_cur.state = ext_bus_pkg::ST_IDLE;
    endcase
    if (reset) begin
      next_cur = '0;
      next_cur.state = ext_bus_pkg::ST_IDLE;
      // strap is sampled by the clocked reset, every reset cycle
      next_cur.ctrl_a = program_width_select ? `CTRL_RESET_PRG16 : `CTRL_RESET_PRG32; // [R16]
      next_cur.ctrl_b = program_width_select ? `CTRL_RESET_PRG16 : `CTRL_RESET_PRG32; // [R16]
    end
  end

  always_ff @(posedge clk_sys) begin
    cur <= next_cur;
  end

  always_comb begin
    set_a_active = in_access & ~cur.req.io & ~cur.req.set_b;
    set_b_active = in_access & ~cur.req.io & cur.req.set_b;
    // ignoring holds keeps the grant high even before the state leaves held
    bus_drive = ~shutdown_high_z & ~(in_held & ~hold_ignore); // [R10] [R17]
    reg_rdata = cur.reg_rdata;
    rsp_valid = cur.rsp_valid;
    rsp_rdata = cur.rdata;
    addr_out = cur.req.addr; // [R1]
    addr_oe = bus_drive & ~reset; // [R1] [R17]
    data_out = cur.req.data >> shift; // [R2]
    data_oe = bus_drive & ~reset & in_access & cur.req.write; // [R2] [R17]
    read_not_write = ~(in_access & cur.req.write); // [R3]
    read_not_write_oe = bus_drive; // [R10]
    peripheral_io_strobe_n = ~(in_access & cur.req.io); // [R4]
    peripheral_io_strobe_oe = bus_drive; // [R10]
    memory_strobe_oe = bus_drive; // [R10]
    bus_hold_grant_n = ~(in_held & ~hold_ignore); // [R12] [R13]
    bus_hold_grant_oe = ~shutdown_high_z; // [R17]
  end

  logic [3:0] fetch_lanes_a;
  logic [3:0] fetch_lanes_b;
  assign fetch_lanes_a = cur.req.fetch ? 4'hF : cur.req.lanes;
  assign fetch_lanes_b = cur.req.fetch ? 4'hF : cur.req.lanes;

  lane_mapper u_lanes_a (
    .width(cur.width),
    .beat(cur.beat),
    .lanes(fetch_lanes_a),
    .active(set_a_active),
    .lanes_n(memory_strobe_set_a_lanes)
  ); // [R5] [R6] [R7]

  lane_mapper u_lanes_b (
    .width(cur.width),
    .beat(cur.beat),
    .lanes(fetch_lanes_b),
    .active(set_b_active),
    .lanes_n(memory_strobe_set_b_lanes)
  ); // [R5] [R6] [R7]

  // checks on the pins, disabled while in reset except a_shutdown_float
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  sequence s_beat_waiting;
    in_access && !ready_in;
  endsequence

  sequence s_hold_from_idle;
    cur.state == ext_bus_pkg::ST_IDLE && !hold_request_n && !hold_ignore && !shutdown_high_z;
  endsequence

  sequence s_bus_floated;
    !bus_hold_grant_n && !addr_oe && !data_oe && !read_not_write_oe && !memory_strobe_oe;
  endsequence

  sequence s_last_beat_done;
    in_access && ready_in && last;
  endsequence

  a_float_when_granted: assert property ( // [R10]
    !bus_hold_grant_n |-> !addr_oe && !data_oe && !read_not_write_oe
      && !memory_strobe_oe && !peripheral_io_strobe_oe)
    else $error("bus driven while hold granted");

  a_hold_grant_follows: assert property ( // [R12]
    s_hold_from_idle ##1 !hold_request_n && !hold_ignore && !shutdown_high_z
      |-> s_bus_floated)
    else $error("hold not granted after request from idle");

  a_grant_high_ignore: assert property ( // [R13]
    hold_ignore |-> bus_hold_grant_n)
    else $error("grant low while holds are ignored");

  a_grant_release: assert property ( // [R13] [R11]
    in_held && hold_request_n |=> bus_hold_grant_n && req_ready)
    else $error("grant not released after request lifted");

  a_wait_for_ready: assert property ( // [R8]
    s_beat_waiting |=> in_access && cur.beat == $past(cur.beat) && !rsp_valid)
    else $error("beat advanced without ready");

  a_no_hold_mid_beat: assert property ( // [R9]
    s_beat_waiting |=> bus_hold_grant_n)
    else $error("hold granted before transaction finished");

  a_held_blocks_req: assert property ( // [R11]
    !bus_hold_grant_n |-> !req_ready ##1 !in_access)
    else $error("request taken while held");

  a_rnw_direction: assert property ( // [R3]
    in_access |-> read_not_write == !cur.req.write)
    else $error("read_not_write wrong for access");

  a_io_strobe_alone: assert property ( // [R4]
    !peripheral_io_strobe_n |-> memory_strobe_set_a_lanes == 4'hF
      && memory_strobe_set_b_lanes == 4'hF)
    else $error("memory strobe with I/O strobe");

  a_lane3_address: assert property ( // [R6]
    set_a_active && cur.width != `WIDTH_32
      |-> memory_strobe_set_a_lanes[3] == cur.beat[0])
    else $error("lane 3 not carrying low address");

  a_lane2_address: assert property ( // [R7]
    set_b_active && cur.width == `WIDTH_8
      |-> memory_strobe_set_b_lanes[2] == cur.beat[1])
    else $error("lane 2 not carrying address in 8-bit mode");

  a_fetch_one_word: assert property ( // [R14]
    rsp_valid && cur.req.fetch && !cur.req.io && cur.width == `WIDTH_32
      |-> cur.beat == 2'h0)
    else $error("32-bit fetch took more than one beat");

  a_fetch_two_halves: assert property ( // [R15]
    accept && req_in.fetch && !req_in.io && cur.ctrl_a[`CTRL_PRG16]
      |=> cur.width == `WIDTH_16 && cur.beat == 2'h0 && !rsp_valid)
    else $error("16-bit fetch did not start with the low half");

  a_fetch_second_half: assert property ( // [R15]
    in_access && cur.req.fetch && cur.width == `WIDTH_16 && cur.beat == 2'h0 && ready_in
      |=> in_access && cur.beat == 2'h1 && !rsp_valid)
    else $error("16-bit fetch ended after one half");

  a_strap_reset: assert property ( // [R16]
    @(posedge clk_sys) $past(reset) && !reset
      |-> cur.ctrl_b[`CTRL_PRG16] == $past(program_width_select))
    else $error("bus-control reset value ignores strap");

  a_shutdown_float: assert property ( // [R17]
    @(posedge clk_sys) disable iff (1'b0)
    shutdown_high_z || reset |-> !addr_oe && !data_oe)
    else $error("address or data driven in shutdown or reset");

  a_shutdown_all_float: assert property ( // [R17]
    shutdown_high_z |-> !bus_hold_grant_oe && !peripheral_io_strobe_oe
      && !memory_strobe_oe && !read_not_write_oe)
    else $error("control pins driven in shutdown");

  a_data_write_only: assert property ( // [R2] [R3]
    data_oe |-> in_access && cur.req.write && !read_not_write)
    else $error("data port driven outside a write");

  a_lane_enables_32: assert property ( // [R5]
    set_b_active && cur.width == `WIDTH_32 && !cur.req.fetch
      |-> memory_strobe_set_b_lanes == ~cur.req.lanes)
    else $error("byte-lane enables do not match request");

  a_lane3_address_b: assert property ( // [R6]
    set_b_active && cur.width != `WIDTH_32
      |-> memory_strobe_set_b_lanes[3] == cur.beat[0])
    else $error("set b lane 3 not carrying low address");

  a_lane2_address_a: assert property ( // [R7]
    set_a_active && cur.width == `WIDTH_8
      |-> memory_strobe_set_a_lanes[2] == cur.beat[1])
    else $error("set a lane 2 not carrying address in 8-bit mode");

  // a register write in the same cycle may set the ignore bit first
  a_hold_after_last: assert property ( // [R9] [R12]
    s_last_beat_done ##0 hold_take && !reg_write |=> !bus_hold_grant_n)
    else $error("hold not granted after last beat");

  a_rsp_after_ready: assert property ( // [R8]
    rsp_valid |-> $past(beat_done))
    else $error("response without ready");

  a_addr_held_wait: assert property ( // [R1] [R8]
    s_beat_waiting |=> $stable(addr_out) && $stable(read_not_write))
    else $error("address or direction moved while waiting");

endmodule // external_memory_bus_interface

// ===== ext_bus_map.svh
// offsets, field positions, reset values and codes of the external bus interface
// assumes a 32-bit register port with byte offsets on an 8-bit address
// Summary of operation
// R1: addresses leave on a 24-bit output port that can float.
// R2: data moves on a 32-bit two-way port, driven on writes, sampled on reads.
// R3: read_not_write is high for every read and low for every write.
// R4: peripheral accesses use their own I/O strobe, apart from both memory strobe sets.
// R5: two memory strobe sets, four byte-lane enables each, one per byte at 32 bits.
// R6: for 8- and 16-bit memory, lane 3 becomes the lowest address bit.
// R7: for 8-bit memory only, lane 2 becomes a further low address bit.
// R8: a transaction ends only once the external side signals ready.
// R9: on a hold request, any transaction under way is finished first.
// R10: once the hold is granted, address, data, strobes and read_not_write float.
// R11: while held, no transactions run until request lifts or hold is ignored.
// R12: hold grant goes low on a low request, showing bus floating and suspended.
// R13: hold grant goes high with a high request and stays high while ignoring holds.
// R14: program width select low fetches each instruction as one 32-bit word.
// R15: program width select high fetches two 16-bit halves and joins them.
// R16: program width select during reset sets both bus-control reset values.
// R17: bus outputs float under shutdown; address and data also float in reset.
// R18: a bus master waits for the grant before driving and releases before lifting.
`ifndef EXT_BUS_MAP_SVH
`define EXT_BUS_MAP_SVH

`define OFF_CTRL_A 8'h00
`define OFF_CTRL_B 8'h04
`define OFF_STATUS 8'h08

`define CTRL_HOLD_IGNORE 0
`define CTRL_WIDTH_LO 1
`define CTRL_PRG16 3
`define CTRL_MASK 32'h0000000F

`define CTRL_RESET_PRG32 32'h00000000
`define CTRL_RESET_PRG16 32'h0000000A

`define WIDTH_32 2'h0
`define WIDTH_16 2'h1
`define WIDTH_8 2'h2

`define STAT_ACCESS 0
`define STAT_HELD 1
`define STAT_HOLD_PENDING 2

`endif

// ===== ext_bus_pkg.sv
// types shared by the external bus interface and its bench
// assumes ext_bus_map.svh for the numeric constants
package ext_bus_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCESS = 2'b01,
    ST_HELD = 2'b10
  } bus_state_t;

  typedef struct packed {
    logic write;
    logic io;
    logic set_b;
    logic fetch;
    logic [23:0] addr;
    logic [31:0] data;
    logic [3:0] lanes;
  } bus_req_t;

  typedef struct packed {
    logic [31:0] ctrl_a;
    logic [31:0] ctrl_b;
    logic [31:0] reg_rdata;
    bus_state_t state;
    bus_req_t req;
    logic [1:0] width;
    logic [1:0] beat;
    logic [31:0] rdata;
    logic rsp_valid;
  } ctrl_state_t;

endpackage

// ===== lane_mapper.sv
// maps one memory strobe set onto its four lane pins for the current width
// assumes width, beat and lane mask come from registered state
`timescale 1ns/1ns
`include "ext_bus_map.svh"
module lane_mapper (
  // access description
  input wire logic [1:0] width,
  input wire logic [1:0] beat,
  input wire logic [3:0] lanes,
  input wire logic active,
  // pins, enables active low except where they carry address
  output logic [3:0] lanes_n
);
  logic [1:0] half;

  always_comb begin
    half = beat[0] ? lanes[3:2] : lanes[1:0];
    case (width)
      `WIDTH_16: begin
        lanes_n[3] = beat[0]; // [R6]
        lanes_n[2] = ~active;
        lanes_n[1:0] = ~(half & {2{active}});
      end
      `WIDTH_8: begin
        lanes_n[3] = beat[0]; // [R6]
        lanes_n[2] = beat[1]; // [R7]
        lanes_n[1] = 1'b1;
        lanes_n[0] = ~(active & lanes[beat]);
      end
      default: begin
        lanes_n = ~(lanes & {4{active}}); // [R5]
      end
    endcase
  end
endmodule // lane_mapper

// ===== ext_mem_model.sv
// behavioural far side: external memory, peripheral and a bus-requesting master
// assumes the bench sets memory width and wait count before each access
`timescale 1ns/1ns
`include "ext_bus_map.svh"
module ext_mem_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // pins from the block
  input wire logic [23:0] addr_out,
  input wire logic [31:0] data_out,
  input wire logic data_oe,
  input wire logic read_not_write,
  input wire logic peripheral_io_strobe_n,
  input wire logic [3:0] memory_strobe_set_a_lanes,
  input wire logic [3:0] memory_strobe_set_b_lanes,
  // answers to the block
  output logic [31:0] data_in,
  output logic ready_in,
  output logic hold_request_n,
  // bench controls and observations
  input wire logic [1:0] mem_width,
  input wire logic [3:0] wait_cycles,
  input wire logic want_hold,
  output logic active,
  output logic [31:0] wr_word
);
  logic [3:0] ln;
  logic [3:0] cnt;
  logic [31:0] word;
  logic [31:0] last;
  // an idle set shows ones on its enables and the same address lanes as the active set, so the and leaves the active set's pins
  assign ln = memory_strobe_set_a_lanes & memory_strobe_set_b_lanes;
  assign word = {8'hC3, addr_out};
  assign active = !peripheral_io_strobe_n || (mem_width == `WIDTH_16 ? !ln[2] :
                  mem_width == `WIDTH_8 ? !ln[0] : ln != 4'hF);
  assign ready_in = active && (cnt == wait_cycles);
  // the master never drives shared lines, so there is nothing to release first
  assign hold_request_n = !want_hold;
  always_comb begin
    data_in = ~last; // released bus: no stale value survives
    if (active && read_not_write) begin
      if (mem_width == `WIDTH_16)
        data_in[15:0] = ln[3] ? word[31:16] : word[15:0];
      else if (mem_width == `WIDTH_8)
        data_in[7:0] = word[8 * {ln[2], ln[3]} +: 8];
      else
        data_in = word;
    end
  end
  always_ff @(posedge clk_sys) begin
    last <= data_in;
    if (reset || !active || ready_in)
      cnt <= 4'h0;
    else
      cnt <= cnt + 4'h1;
    if (active && ready_in && !read_not_write && data_oe)
      wr_word <= data_out;
  end
endmodule // ext_mem_model

// ===== external_memory_bus_interface_tb_top.sv
// self-checking bench for the external bus sequencer
// assumes the partner model answers every strobe; clock 25 MHz
`timescale 1ns/1ns
`include "ext_bus_map.svh"
module external_memory_bus_interface_tb_top;
  logic clk_sys = 1'h0;
  logic reset = 1'h1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'h0, reg_read = 1'h0, req_valid = 1'h0;
  logic program_width_select = 1'h1, shutdown_high_z = 1'h0, want_hold = 1'h0;
  ext_bus_pkg::bus_req_t req_in = '0;
  logic [31:0] reg_rdata, rsp_rdata, data_in, data_out, wr_word, r;
  logic [23:0] addr_out, last_addr;
  logic req_ready, rsp_valid, addr_oe, data_oe, read_not_write, read_not_write_oe;
  logic peripheral_io_strobe_n, peripheral_io_strobe_oe, memory_strobe_oe, ready_in;
  logic hold_request_n, bus_hold_grant_n, bus_hold_grant_oe, active;
  logic [3:0] memory_strobe_set_a_lanes, memory_strobe_set_b_lanes, seen_lo, seen_hi;
  logic [3:0] wait_cycles = 4'h0;
  logic [1:0] mem_width = `WIDTH_16;
  logic mon_b = 1'h0, saw_wr, saw_io;
  int act_cyc, error_cnt = 0, check_count = 0;

  always #20 clk_sys = ~clk_sys;

  external_memory_bus_interface dut (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .req_valid, .req_ready, .req_in, .rsp_valid, .rsp_rdata,
    .addr_out, .addr_oe, .data_in, .data_out, .data_oe, .read_not_write, .read_not_write_oe,
    .peripheral_io_strobe_n, .peripheral_io_strobe_oe, .memory_strobe_set_a_lanes,
    .memory_strobe_set_b_lanes, .memory_strobe_oe, .ready_in, .hold_request_n,
    .bus_hold_grant_n, .bus_hold_grant_oe, .program_width_select, .shutdown_high_z);

  ext_mem_model far_side (.clk_sys, .reset, .addr_out, .data_out, .data_oe, .read_not_write,
    .peripheral_io_strobe_n, .memory_strobe_set_a_lanes, .memory_strobe_set_b_lanes,
    .data_in, .ready_in, .hold_request_n, .mem_width, .wait_cycles, .want_hold, .active,
    .wr_word);

  always @(posedge clk_sys) begin
    if (active) begin
      act_cyc <= act_cyc + 1;
      last_addr <= addr_out;
      seen_lo <= seen_lo | ~(mon_b ? memory_strobe_set_b_lanes : memory_strobe_set_a_lanes);
      seen_hi <= seen_hi | (mon_b ? memory_strobe_set_b_lanes : memory_strobe_set_a_lanes);
      if (!read_not_write) saw_wr <= 1'h1;
      if (!peripheral_io_strobe_n) saw_io <= 1'h1;
    end
  end

  function automatic logic [31:0] pat(input logic [23:0] a);
    return {8'hC3, a};
  endfunction

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'h1) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic timeout(input string msg);
    check(1'h0, msg);
    tally_and_finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(posedge clk_sys);
    reg_write <= 1'h0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge clk_sys);
    reg_read <= 1'h0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask

  task automatic do_req(input logic w, io, b, f, input logic [23:0] a, input logic [31:0] d,
                        input logic [3:0] ln, input logic wait_rsp);
    int n;
    @(posedge clk_sys);
    req_in <= '{write: w, io: io, set_b: b, fetch: f, addr: a, data: d, lanes: ln};
    req_valid <= 1'h1;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (req_ready !== 1'h1 && n < 50);
    if (req_ready !== 1'h1) timeout("request never taken");
    {act_cyc, seen_lo, seen_hi, saw_wr, saw_io} = '0;
    @(posedge clk_sys);
    req_valid <= 1'h0;
    if (wait_rsp) get_rsp();
  endtask

  task automatic get_rsp;
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (rsp_valid !== 1'h1 && n < 50);
    if (rsp_valid !== 1'h1) timeout("no response");
    r = rsp_rdata;
  endtask

  task automatic t_reset;
    @(negedge clk_sys);
    check(addr_oe === 1'h0 && data_oe === 1'h0, "bus driven in reset");
    repeat (4) @(posedge clk_sys);
    reset <= 1'h0;
    reg_rd(`OFF_CTRL_A, r);
    check(r === `CTRL_RESET_PRG16, "ctrl_a reset value");
    reg_rd(`OFF_CTRL_B, r);
    check(r === `CTRL_RESET_PRG16, "ctrl_b reset value");
    reg_rd(8'h0C, r);
    check(r === 32'h0, "unmapped read");
    $display("reset test done");
  endtask

  task automatic t_fetch;
    do_req(1'h0, 1'h0, 1'h0, 1'h1, 24'h000123, 32'h0, 4'hF, 1'h1);
    check(r === pat(24'h000123) && act_cyc === 2, "16-bit fetch");
    check(seen_lo[3] === 1'h1 && seen_hi[3] === 1'h1, "lane3 address bit");
    reg_wr(`OFF_CTRL_A, 32'h0);
    mem_width = `WIDTH_32;
    do_req(1'h0, 1'h0, 1'h0, 1'h1, 24'hABCDEF, 32'h0, 4'hF, 1'h1);
    check(r === pat(24'hABCDEF) && act_cyc === 1, "32-bit fetch");
    $display("fetch test done");
  endtask

  task automatic t_rw32;
    wait_cycles = 4'h2;
    do_req(1'h0, 1'h0, 1'h0, 1'h0, 24'h00F00D, 32'h0, 4'hF, 1'h1);
    check(r === pat(24'h00F00D) && act_cyc === 3, "read with waits");
    check(saw_wr === 1'h0 && seen_lo === 4'hF, "read direction or lanes");
    wait_cycles = 4'h0;
    do_req(1'h1, 1'h0, 1'h0, 1'h0, 24'h800001, 32'h1234ABCD, 4'h5, 1'h1);
    check(wr_word === 32'h1234ABCD && last_addr === 24'h800001, "write data");
    check(saw_wr === 1'h1, "write direction");
    check(seen_lo === 4'h5 && seen_hi === 4'hA, "write byte lanes");
    do_req(1'h0, 1'h1, 1'h0, 1'h0, 24'h000042, 32'h0, 4'hF, 1'h1);
    check(r === pat(24'h000042) && saw_io === 1'h1 && seen_lo === 4'h0, "io strobe");
    reg_wr(`OFF_CTRL_B, 32'h4);
    mem_width = `WIDTH_8;
    mon_b = 1'h1;
    do_req(1'h0, 1'h0, 1'h1, 1'h0, 24'h00BEEF, 32'h0, 4'hF, 1'h1);
    check(r === pat(24'h00BEEF) && act_cyc === 4, "8-bit read");
    check(seen_lo[3:2] === 2'h3 && seen_hi[3:2] === 2'h3, "8-bit address lanes");
    mem_width = `WIDTH_32;
    mon_b = 1'h0;
    $display("access test done");
  endtask

  task automatic t_hold;
    wait_cycles = 4'h3;
    do_req(1'h0, 1'h0, 1'h0, 1'h0, 24'h000777, 32'h0, 4'hF, 1'h0);
    want_hold <= 1'h1;
    get_rsp();
    check(r === pat(24'h000777) && act_cyc === 4, "access cut by hold");
    repeat (2) @(negedge clk_sys);
    check(bus_hold_grant_n === 1'h0 && bus_hold_grant_oe === 1'h1, "grant");
    check({addr_oe, data_oe, read_not_write_oe, peripheral_io_strobe_oe, memory_strobe_oe}
          === 5'h0, "bus not floated");
    check(req_ready === 1'h0, "request taken while held");
    reg_rd(`OFF_STATUS, r);
    check(r === (32'h1 << `STAT_HELD | 32'h1 << `STAT_HOLD_PENDING), "held status");
    @(posedge clk_sys);
    want_hold <= 1'h0;
    repeat (2) @(negedge clk_sys);
    check(bus_hold_grant_n === 1'h1 && addr_oe === 1'h1, "grant not returned");
    wait_cycles = 4'h0;
    reg_wr(`OFF_CTRL_A, 32'h1);
    want_hold <= 1'h1;
    repeat (3) @(negedge clk_sys);
    check(bus_hold_grant_n === 1'h1, "grant under hold ignore");
    do_req(1'h0, 1'h0, 1'h0, 1'h0, 24'h000101, 32'h0, 4'hF, 1'h1);
    check(r === pat(24'h000101), "access under hold ignore");
    want_hold <= 1'h0;
    reg_wr(`OFF_CTRL_A, 32'h0);
    $display("hold test done");
  endtask

  task automatic t_shutdown;
    @(posedge clk_sys);
    shutdown_high_z <= 1'h1;
    @(negedge clk_sys);
    check({addr_oe, data_oe, read_not_write_oe, peripheral_io_strobe_oe, memory_strobe_oe,
           bus_hold_grant_oe} === 6'h0, "outputs in shutdown");
    @(posedge clk_sys);
    shutdown_high_z <= 1'h0;
    $display("shutdown test done");
  endtask

  initial begin
    t_reset();
    t_fetch();
    t_rw32();
    t_hold();
    t_shutdown();
    tally_and_finish();
  end
endmodule // external_memory_bus_interface_tb_top
